// file: logic/prm_meter.sv
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
// What this block does
// - three-bit code picks one of eight rates
// - thresholds at 2:0, 6:4, 10:8, 14:12
// - count-control bit sits above each threshold
// - bit zero: length charged to source port
// - reset: thresholds 000, count bits 0
// - indices 78h..7Ch hold ports 0..19
// - meter acts only when enable set; resets 0
module prm_meter
	import prm_pkg::*;
#(
	parameter int WIN_CYC = prm_pkg::PRM_WIN_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [prm_pkg::PRM_NPORT-1:0] rx_pkt_valid,
	input wire logic [10:0] rx_pkt_len [prm_pkg::PRM_NPORT],
	output logic [prm_pkg::PRM_NPORT-1:0] rx_drop,
	output logic [prm_pkg::PRM_NPORT-1:0] over_rate
);
	import prm_pkg::*;

	// limitations
	// the meter charges whole packets on the cycle rx_pkt_valid pulses; a
	// packet longer than the budget of its port's rate can never pass
	// one packet per port per cycle; a second pulse in the next cycle is
	// judged against the accumulator as updated by the first
	// config changes apply from the next cycle; the accumulator is not
	// cleared when a rate code or enable changes, only at window end
	// a disabled port keeps its accumulator, and over_rate reads low for it

	// elaboration checks; the logic below relies on these relations
	// the window needs at least one counting cycle
	if (WIN_CYC < 1) begin : g_bad_win
		$error("window must be at least one cycle");
	end

	// every port owns exactly one field of one config word
	if (PRM_NPORT != PRM_NREG * PRM_PPR) begin : g_bad_map
		$error("port count does not match the config words");
	end

	// four fields of threshold plus count bit fill one word
	if (PRM_FLD_W * PRM_PPR != PRM_REG_W || PRM_CNT_BIT != PRM_THR_W) begin : g_bad_fld
		$error("field layout does not fill a config word");
	end

	// the high enable register holds the ports above the low word
	if (PRM_NPORT <= PRM_EN_LO_W || PRM_NPORT > 2 * PRM_EN_LO_W) begin : g_bad_en
		$error("enable split needs between 17 and 32 ports");
	end

	// slots are three bits wide: config words, two enables, one gap
	if (PRM_NREG + 2 > int'(PRM_SLOT_NONE)) begin : g_bad_slot
		$error("too many config words for the slot code");
	end

	// the decoded address bits must form one index byte
	if (PRM_IDX_MSB - PRM_IDX_LSB + 1 != $bits(PRM_IDX_P0_3)) begin : g_bad_idx
		$error("index field width does not match the index constants");
	end

	// the widest budget must fit the accumulator
	if (PRM_CNT_W < $clog2(int'(PRM_LIM_20M)) + 1) begin : g_bad_cnt
		$error("accumulator too narrow for the largest budget");
	end

	// rate codes
	// budgets are bytes per window at the nominal clock and a 1 ms window;
	// a different WIN_CYC scales the window but not the budgets, so
	// simulation with a short window sees much higher effective rates

	// rate code to byte budget per window
	function automatic logic [PRM_CNT_W-1:0] lim_of(input logic [PRM_THR_W-1:0] code);
		case (code)
			3'h0: lim_of = PRM_LIM_64K;
			3'h1: lim_of = PRM_LIM_128K;
			3'h2: lim_of = PRM_LIM_256K;
			3'h3: lim_of = PRM_LIM_512K;
			3'h4: lim_of = PRM_LIM_1M;
			3'h5: lim_of = PRM_LIM_4M;
			3'h6: lim_of = PRM_LIM_10M;
			default: lim_of = PRM_LIM_20M;
		endcase
	endfunction

	// register slot of an index; enables and gaps get fixed slots
	function automatic logic [2:0] slot_of(input logic [7:0] idx);
		if (idx >= PRM_IDX_P0_3 && idx <= PRM_IDX_P16_19) begin
			slot_of = 3'(idx - PRM_IDX_P0_3);
		end else if (idx == PRM_IDX_EN_LO) begin
			slot_of = PRM_SLOT_EN_LO;
		end else if (idx == PRM_IDX_EN_HI) begin
			slot_of = PRM_SLOT_EN_HI;
		end else begin
			// 7Dh and 7Eh hold ports outside this block
			slot_of = PRM_SLOT_NONE;
		end
	endfunction

	// threshold code of a port inside its config word
	function automatic logic [PRM_THR_W-1:0] thr_of(input logic [PRM_REG_W-1:0] w, input int q);
		thr_of = w[q * PRM_FLD_W +: PRM_THR_W];
	endfunction

	// length-count control bit, one above the threshold field
	function automatic logic cnt_of(input logic [PRM_REG_W-1:0] w, input int q);
		cnt_of = w[q * PRM_FLD_W + PRM_CNT_BIT];
	endfunction

	// register file state
	// five config words, one per group of four ports, all reset to zero
	// enables kept as one vector; low word at 7Fh, ports 16-19 at 80h
	// a write is applied one cycle late, in its data phase, when hwdata stands
	// wslot_r remembers where that pending write goes

	logic [15:0] cfg_r [PRM_NREG];
	logic [15:0] cfg_nxt [PRM_NREG];
	logic [PRM_NPORT-1:0] en_r;
	logic [PRM_NPORT-1:0] en_nxt;
	logic wr_pend_r;
	logic wr_pend_nxt;
	logic [2:0] wslot_r;
	logic [2:0] wslot_nxt;
	logic [31:0] hrdata_nxt;
	logic [2:0] aslot;
	logic take;

	// a transfer is taken only on a NONSEQ with hready high
	// hsize is not checked: every register is one aligned word
	// only the index bits are decoded, so higher addresses alias
	// clk_en low stalls the pending write; the master sees no wait state,
	// so software must not drive the bus while the block is frozen
	assign take = hsel && hready && (htrans == PRM_HTRANS_NONSEQ);
	assign aslot = slot_of(haddr[PRM_IDX_MSB:PRM_IDX_LSB]);

	// bus behaviour
	// zero wait states: hreadyout is always high, hresp always okay
	// read data is fetched in the address phase and stands in the data
	// phase until the next taken transfer; a taken write clears it to zero
	// unmapped indices read as zero and ignore writes
	// the config words are 16 bits; upper read bits are zero

	// bus next state; zero-wait slave, reads answered in data phase
	always_comb begin
		cfg_nxt = cfg_r;
		en_nxt = en_r;
		wr_pend_nxt = 1'b0;
		wslot_nxt = wslot_r;
		hrdata_nxt = hrdata;
		// data phase of a write lands the word in the slot it addressed
		if (wr_pend_r) begin
			case (wslot_r)
				PRM_SLOT_EN_LO: begin
					en_nxt[PRM_EN_LO_W-1:0] = hwdata[PRM_EN_LO_W-1:0];
				end
				PRM_SLOT_EN_HI: begin
					// only ports 16 to 19 exist here; higher bits are dropped
					en_nxt[PRM_NPORT-1:PRM_EN_LO_W] = hwdata[PRM_NPORT-PRM_EN_LO_W-1:0];
				end
				PRM_SLOT_NONE: begin
					wr_pend_nxt = 1'b0;
				end
				default: begin
					if (wslot_r < 3'(PRM_NREG)) begin
						cfg_nxt[wslot_r] = hwdata[PRM_REG_W-1:0];
					end
				end
			endcase
		end
		// address phase: note the slot, and fetch read data now
		if (take) begin
			wr_pend_nxt = hwrite;
			wslot_nxt = aslot;
			hrdata_nxt = 32'h00000000;
			// a read right after a write to the same slot sees the new value
			if (!hwrite) begin
				case (aslot)
					PRM_SLOT_EN_LO: begin
						hrdata_nxt = 32'(en_nxt[PRM_EN_LO_W-1:0]);
					end
					PRM_SLOT_EN_HI: begin
						hrdata_nxt = 32'(en_nxt[PRM_NPORT-1:PRM_EN_LO_W]);
					end
					PRM_SLOT_NONE: begin
						hrdata_nxt = 32'h00000000;
					end
					default: begin
						if (aslot < 3'(PRM_NREG)) begin
							hrdata_nxt = 32'(cfg_nxt[aslot]);
						end
					end
				endcase
			end
		end
	end

	// bus registers; hreadyout and hresp are constants but still come from
	// flops so that every output of the block leaves a register
	// clk_en low holds everything, including a write waiting for its data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < PRM_NREG; i++) begin
				cfg_r[i] <= PRM_CFG_RST;
			end
			en_r <= PRM_EN_RST;
			wr_pend_r <= 1'b0;
			wslot_r <= 3'h0;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else if (clk_en) begin
			cfg_r <= cfg_nxt;
			en_r <= en_nxt;
			wr_pend_r <= wr_pend_nxt;
			wslot_r <= wslot_nxt;
			hrdata <= hrdata_nxt;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// metering
	// each enabled port owns a byte accumulator that restarts every window
	// the budget per window follows from the port's rate code
	// a packet that would push the accumulator past the budget is dropped
	// whole; a dropped packet is not charged, so later small packets may pass
	// trade-off: a fixed window is cheap but lets a burst of up to twice the
	// budget through across a window boundary
	// the count bit set exempts the port: nothing is charged or dropped

	// per-port metering state
	logic [PRM_CNT_W-1:0] acc_r [PRM_NPORT];
	logic [PRM_CNT_W-1:0] acc_nxt [PRM_NPORT];
	logic [31:0] win_r;
	logic [31:0] win_nxt;
	logic [PRM_NPORT-1:0] drop_nxt;
	logic [PRM_NPORT-1:0] over_nxt;
	logic win_end;

	// window timing
	// win_r counts hclk cycles while clk_en is high; a frozen clock enable
	// stretches the window, which only makes the meter more lenient
	assign win_end = (win_r == 32'(WIN_CYC - 1));

	// bytes accumulate per window; packets beyond budget are dropped
	always_comb begin
		logic [PRM_THR_W-1:0] code;
		logic cnt_sel;
		logic [PRM_CNT_W-1:0] lim;
		logic [PRM_CNT_W-1:0] sum;
		code = '0;
		cnt_sel = 1'b0;
		lim = '0;
		sum = '0;
		// free-running window counter, wraps at the last cycle
		win_nxt = win_end ? 32'h00000000 : win_r + 32'h00000001;
		for (int p = 0; p < PRM_NPORT; p++) begin
			// settings of this port from its config word
			code = thr_of(cfg_r[p / PRM_PPR], p % PRM_PPR);
			cnt_sel = cnt_of(cfg_r[p / PRM_PPR], p % PRM_PPR);
			lim = lim_of(code);
			// the length is widened before adding
			sum = acc_r[p] + PRM_CNT_W'(rx_pkt_len[p]);
			// window end clears; a packet on that cycle is checked, not added
			acc_nxt[p] = win_end ? '0 : acc_r[p];
			drop_nxt[p] = 1'b0;
			// level flag: budget used up while metering is enabled
			over_nxt[p] = en_r[p] && (acc_r[p] >= lim);
			// count bit 1 leaves the length uncharged to the source
			if (rx_pkt_valid[p] && en_r[p] && !cnt_sel) begin
				// the wrap test guards against an accumulator overflow
				if (sum > lim || sum < acc_r[p]) begin
					drop_nxt[p] = 1'b1;
				end else if (!win_end) begin
					acc_nxt[p] = sum;
				end
			end
		end
	end

	// meter registers; rx_drop is a one-cycle pulse, over_rate a level
	// both are registered; rx_drop trails the packet by one cycle, over_rate by two
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int p = 0; p < PRM_NPORT; p++) begin
				acc_r[p] <= '0;
			end
			win_r <= 32'h00000000;
			rx_drop <= '0;
			over_rate <= '0;
		end else if (clk_en) begin
			acc_r <= acc_nxt;
			win_r <= win_nxt;
			rx_drop <= drop_nxt;
			over_rate <= over_nxt;
		end
	end
endmodule

// file: logic/prm_pkg.sv
package prm_pkg;
	// register indices; byte address is index times four
	localparam logic [7:0] PRM_IDX_P0_3 = 8'h78;
	localparam logic [7:0] PRM_IDX_P4_7 = 8'h79;
	localparam logic [7:0] PRM_IDX_P8_11 = 8'h7A;
	localparam logic [7:0] PRM_IDX_P12_15 = 8'h7B;
	localparam logic [7:0] PRM_IDX_P16_19 = 8'h7C;
	// enable bits: ports 0-15 at 7Fh, ports 16-19 at 80h bits 3:0
	localparam logic [7:0] PRM_IDX_EN_LO = 8'h7F;
	localparam logic [7:0] PRM_IDX_EN_HI = 8'h80;
	localparam int PRM_EN_LO_W = 16;
	localparam int PRM_REG_W = 16;
	// word index bits of the byte address
	localparam int PRM_IDX_LSB = 2;
	localparam int PRM_IDX_MSB = 9;
	// internal slot codes of the two enable words and of a gap
	localparam logic [2:0] PRM_SLOT_EN_LO = 3'h5;
	localparam logic [2:0] PRM_SLOT_EN_HI = 3'h6;
	localparam logic [2:0] PRM_SLOT_NONE = 3'h7;
	localparam int PRM_NPORT = 20;
	localparam int PRM_NREG = 5;
	localparam int PRM_PPR = 4;
	localparam int PRM_FLD_W = 4;
	localparam int PRM_THR_W = 3;
	localparam int PRM_CNT_BIT = 3;
	localparam logic [15:0] PRM_CFG_RST = 16'h0000;
	localparam logic [PRM_NPORT-1:0] PRM_EN_RST = '0;
	// window for byte accounting: 1 ms
	localparam int PRM_WIN_US = 1000;
	localparam int PRM_CLK_MHZ = 100;
	localparam int PRM_WIN_CYC = PRM_WIN_US * PRM_CLK_MHZ;
	localparam int PRM_CNT_W = 24;
	localparam logic [1:0] PRM_HTRANS_NONSEQ = 2'b10;
	localparam logic [2:0] PRM_HSIZE_WORD = 3'b010;
	// bytes allowed per window for each code (bits/s / 64, but 156325 for 10M)
	localparam logic [PRM_CNT_W-1:0] PRM_LIM_64K = 24'h0003E8;
	localparam logic [PRM_CNT_W-1:0] PRM_LIM_128K = 24'h0007D0;
	localparam logic [PRM_CNT_W-1:0] PRM_LIM_256K = 24'h000FA0;
	localparam logic [PRM_CNT_W-1:0] PRM_LIM_512K = 24'h001F40;
	localparam logic [PRM_CNT_W-1:0] PRM_LIM_1M = 24'h003D09;
	localparam logic [PRM_CNT_W-1:0] PRM_LIM_4M = 24'h00F424;
	localparam logic [PRM_CNT_W-1:0] PRM_LIM_10M = 24'h0262A5;
	localparam logic [PRM_CNT_W-1:0] PRM_LIM_20M = 24'h04C4B4;
endpackage

// file: testbench/prm_meter_monitor.sv
`timescale 1ns/1ps
module prm_meter_monitor(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [19:0] rx_pkt_valid,
	input wire logic [19:0] rx_drop,
	input wire logic [19:0] over_rate
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// taken read; hready is always high, so left out
	logic rd;
	assign rd = clk_en & hsel & htrans == 2'h2 & !hwrite;
	a_resp_okay: assert property (!hresp) else $error("resp");
	a_ready_high: assert property (hreadyout) else $error("wait");
	a_reset_quiet: assert property ($rose(hresetn) |-> !rx_drop && !hrdata)
		else $error("rst");
	a_drop_cause: assert property (!(rx_drop & ~$past(rx_pkt_valid)))
		else $error("drop");
	a_read_hold: assert property (!$past(rd) |-> $stable(hrdata)) else $error("hold");
	a_unmapped_zero: assert property ($past(rd && haddr[9:2] == 8'h7D) |-> !hrdata)
		else $error("map");
	a_upper_zero: assert property (!hrdata[31:16]) else $error("upper");
	a_freeze_hold: assert property (!$past(clk_en) |-> $stable(over_rate))
		else $error("freeze");
	c_drop: cover property (|rx_drop);
	c_over: cover property (|over_rate);
	c_read: cover property (rd);
endmodule
bind prm_meter prm_meter_monitor u_mon(.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans,
	.hwrite, .hrdata, .hreadyout, .hresp, .rx_pkt_valid, .rx_drop, .over_rate);

// file: testbench/port_ingress_rate_meter_cfg_tb_top.sv
`timescale 1ns/1ps
module port_ingress_rate_meter_cfg_tb_top;
	logic hclk = 1'h0, hresetn = 1'h0, clk_en = 1'h0, hsel = 1'h0, hwrite = 1'h0, e;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
	logic [19:0] vld = '0, rx_drop, ovr;
	logic [10:0] len [20];
	logic hreadyout;
	int failures = 0, checked = 0, acc, k;
	always #5 hclk = ~hclk;
	// long window so no accumulator clear lands inside a test
	prm_meter #(.WIN_CYC(60000)) u_prm_meter(.hclk, .hresetn, .clk_en, .hsel, .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
		.hresp(), .rx_pkt_valid(vld), .rx_pkt_len(len), .rx_drop, .over_rate(ovr));
	task final_report;
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(string n, logic [31:0] x, y);
		checked++;
		if (x !== y) begin
			$display("mismatch %s exp %h got %h", n, x, y);
			failures++;
		end
	endtask
	// bounded wait for hready
	task hw;
		@(posedge hclk);
		for (k = 0; hreadyout !== 1'h1; k++) begin
			if (k == 50) begin
				failures++;
				final_report;
			end
			@(posedge hclk);
		end
	endtask
	task xf(logic w, logic [7:0] i, logic [31:0] d);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, i, 2'h0};
		hw;
		htrans <= 2'h0;
		hwdata <= d;
		hw;
		r = hrdata;
	endtask
	// one 500-byte packet, drop seen the cycle after
	task pk(int p);
		vld[p] <= 1'h1;
		len[p] <= 11'h1F4;
		@(posedge hclk);
		vld[p] <= 1'h0;
		@(negedge hclk);
		chk("rx_drop", e, rx_drop[p]);
		@(posedge hclk);
	endtask
	task rst;
		hresetn <= 1'h0;
		clk_en <= 1'h0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'h1;
		clk_en <= 1'h1;
		hsel <= 1'h1;
		@(posedge hclk);
	endtask
	initial begin
		foreach (len[i]) len[i] = 11'h0;
		rst;
		// reset values, then write all ones above the fields
		for (int i = 0; i < 9; i++) begin
			xf(1'h0, 8'h78 + i[7:0], '0);
			chk("reset", '0, r);
			xf(1'h1, 8'h78 + i[7:0], {16'hFFFF, 16'hA5C3 ^ i[15:0]});
			xf(1'h0, 8'h78 + i[7:0], '0);
			chk("cfg", i < 5 || i == 7 ? {16'h0, 16'hA5C3 ^ i[15:0]} : i == 8 ? 32'hB : '0, r);
		end
		// port 17: code 0, code 1, count bit set, disabled
		for (int m = 0; m < 4; m++) begin
			rst;
			xf(1'h1, 8'h7C, {24'h0, m == 2, m == 1 ? 3'h1 : 3'h0, 4'h0});
			xf(1'h1, 8'h80, {30'h0, m != 3, 1'h0});
			acc = 0;
			repeat (5) begin
				e = m < 2 && acc + 500 > 1000 * (m + 1);
				pk(17);
				acc += e ? 0 : 500;
			end
			chk("over_rate", m < 2, ovr[17]);
		end
		final_report;
	end
endmodule
